// ==== sar_sequencer_params.svh ====
`ifndef SAR_SEQUENCER_PARAMS_SVH
`define SAR_SEQUENCER_PARAMS_SVH
// result width of the converter
`define RESULT_WIDTH 18
// conversion time bounds in ns
`define CONV_MIN_NS 300
`define CONV_MAX_NS 500
// clock period in ns
`define CLK_PERIOD_NS 20
// least conversion time rounds up, longest rounds down
`define CONV_MIN_CYC ((`CONV_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_MAX_CYC (`CONV_MAX_NS / `CLK_PERIOD_NS)
// interface clock source selections
`define XFER_SRC_OSC 2'h0
`define XFER_SRC_HOST 2'h1
`define XFER_SRC_MIXED 2'h2
// lfsr reset seed for conversion length jitter
`define JITTER_SEED 4'h9
`endif

// ==== sar_sequencer_pkg.sv ====
package sar_sequencer_pkg;
  // sequencer phases, one-hot
  typedef enum logic [2:0] {
    PH_RESET = 3'b001,
    PH_ACQUIRE = 3'b010,
    PH_CONVERT = 3'b100
  } phase_type;
endpackage : sar_sequencer_pkg

// ==== sar_core_if.sv ====
`include "sar_sequencer_params.svh"
interface sar_core_if;
  // sampling switches closed (tracking)
  logic track;
  // one pulse per successive-approximation step
  logic step;
  // bit weight being resolved this step
  logic [`RESULT_WIDTH-1:0] trial;
  // signed difference held on the array
  logic signed [`RESULT_WIDTH-1:0] held;
  modport seq (output track, output step, output trial, input held);
  modport array (input track, input step, input trial, output held);
endinterface : sar_core_if

// ==== sar_sample_array.sv ====
`include "sar_sequencer_params.svh"
module sar_sample_array #(
  parameter int WIDTH = `RESULT_WIDTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // analog inputs as digitised levels
  input wire logic signed [WIDTH-1:0] analog_in_pos_i,
  input wire logic signed [WIDTH-1:0] analog_in_neg_i,
  // link to sequencer
  sar_core_if.array core
);
  logic signed [WIDTH-1:0] pos_q;
  logic signed [WIDTH-1:0] neg_q;
  logic signed [WIDTH:0] diff;
  logic signed [WIDTH-1:0] sat;
  // each input tracks its own capacitor while switches are closed
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pos_q <= '0;
      neg_q <= '0;
    end else if (core.track) begin // R9
      pos_q <= analog_in_pos_i;
      neg_q <= analog_in_neg_i;
    end
  end
  // difference of held values, clipped to full scale
  assign diff = {pos_q[WIDTH-1], pos_q} - {neg_q[WIDTH-1], neg_q}; // R9
  assign sat = (diff[WIDTH] != diff[WIDTH-1]) ?
    {diff[WIDTH], {(WIDTH-1){~diff[WIDTH]}}} : diff[WIDTH-1:0];
  assign core.held = sat;
  // held values must not move while the sequencer steps through the bits
  chk_held_frozen: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
    core.step |=> $stable(core.held))
    else $error("held difference moved during conversion");
  chk_trial_onehot: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R9
    core.step |-> $onehot(core.trial))
    else $error("trial weight not a single bit");
endmodule : sar_sample_array

// ==== sar_conversion_sequencer.sv ====
// Summary of operation
// R1: start of conversion captures the positive minus negative input onto the array.
// R2: conversion steps are timed by the internal oscillator enable only.
// R3: inputs stay disconnected from the array for the whole conversion.
// R4: after conversion the array reconnects and acquisition resumes.
// R5: takes reset and start from interface; returns status and result.
// R6: result is two's complement; negative inputs set the top bit.
// R7: conversion length varies but stays within minimum and maximum bounds.
// R8: interface transfers may use oscillator, host clock or both.
// R9: each input sampled separately; conversion resolves positive minus negative.
// R10: a rising start edge moves acquisition to conversion.
// R11: start transitions are ignored while converting.
// R12: status is low during conversion and high when it ends.
// R13: acquisition is entered at power-up, after reset, after each conversion.
// R14: start is synchronised before edge detection to prevent double starts.
`include "sar_sequencer_params.svh"
module sar_conversion_sequencer #(
  parameter int WIDTH = `RESULT_WIDTH,
  parameter int MIN_CYC = `CONV_MIN_CYC,
  parameter int MAX_CYC = `CONV_MAX_CYC
) (
  // clock and reset from interface section
  input wire logic clk_i,
  input wire logic rst_b_i,
  // conversion control from interface section
  input wire logic conversion_start_i,
  input wire logic [1:0] xfer_source_i,
  // analog inputs as digitised levels
  input wire logic signed [WIDTH-1:0] analog_in_pos_i,
  input wire logic signed [WIDTH-1:0] analog_in_neg_i,
  // status and result back to interface section
  output logic conversion_status_o,
  output logic [WIDTH-1:0] result_o,
  output logic convert_phase_o,
  output logic sample_switch_o,
  output logic xfer_use_osc_o,
  output logic xfer_use_host_o
);
  localparam int CW = $clog2(MAX_CYC + 2);
  localparam logic [CW-1:0] MIN_C = CW'(MIN_CYC);
  localparam logic [CW-1:0] MAX_C = CW'(MAX_CYC);
  // shortest picked length leaves one step per result bit plus the cycle that loads the result
  localparam int LO_CYC = (MIN_CYC > WIDTH + 1) ? MIN_CYC : WIDTH + 1;
  localparam logic [CW-1:0] LO_C = CW'(LO_CYC);

  sar_core_if core ();
  sar_sequencer_pkg::phase_type state_q, state_d;
  logic sync1_q, sync2_q, start_prev_q;
  logic [1:0] acq_hist_q;
  logic [CW-1:0] conv_run_q;
  logic [3:0] lfsr_q;
  logic [CW-1:0] cnt_q, len_q;
  logic [WIDTH-1:0] approx_q, trial_q;
  logic osc_en;
  logic start_edge;
  logic conv_done;
  logic [CW-1:0] len_pick;

  // clip a candidate length into the legal window
  function automatic logic [CW-1:0] clamp_len(input logic [CW-1:0] v);
    clamp_len = (v < LO_C) ? LO_C : ((v > MAX_C) ? MAX_C : v);
  endfunction : clamp_len

  sar_sample_array #(.WIDTH(WIDTH)) u_array (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .analog_in_pos_i(analog_in_pos_i),
    .analog_in_neg_i(analog_in_neg_i),
    .core(core)
  );

  // two-flop synchroniser, edge taken only from second flop
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      start_prev_q <= 1'b0;
      acq_hist_q <= 2'h0;
    end else begin
      sync1_q <= conversion_start_i; // R14
      sync2_q <= sync1_q;
      start_prev_q <= sync2_q;
      // phase two edges back, so a pin change made while converting but seen late is refused
      acq_hist_q <= {acq_hist_q[0], state_q == sar_sequencer_pkg::PH_ACQUIRE}; // R11
    end
  end

  // decode of phase, edge and completion
  assign osc_en = 1'b1; // R2 internal oscillator ticks every cycle
  assign start_edge = sync2_q & ~start_prev_q & acq_hist_q[1]; // R10 R11 R14
  assign conv_done = (state_q == sar_sequencer_pkg::PH_CONVERT) && (cnt_q == len_q);
  assign len_pick = clamp_len(MIN_C + CW'(lfsr_q)); // R7
  assign core.track = (state_q == sar_sequencer_pkg::PH_ACQUIRE) && !start_edge; // R3 R4
  assign core.step = (state_q == sar_sequencer_pkg::PH_CONVERT) && osc_en && (trial_q != '0);
  assign core.trial = trial_q;

  // next phase
  always_comb begin
    state_d = state_q;
    case (state_q)
      sar_sequencer_pkg::PH_RESET: state_d = sar_sequencer_pkg::PH_ACQUIRE; // R13
      sar_sequencer_pkg::PH_ACQUIRE: if (start_edge) state_d = sar_sequencer_pkg::PH_CONVERT; // R10 R1
      sar_sequencer_pkg::PH_CONVERT: if (conv_done) state_d = sar_sequencer_pkg::PH_ACQUIRE; // R4 R11 R13
      default: state_d = sar_sequencer_pkg::PH_RESET;
    endcase
  end

  // phase register and length jitter source
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= sar_sequencer_pkg::PH_RESET;
      lfsr_q <= `JITTER_SEED;
    end else begin
      state_q <= state_d;
      lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
    end
  end

  // conversion timer, length latched at start
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
      len_q <= MIN_C;
    end else if (state_q == sar_sequencer_pkg::PH_ACQUIRE && start_edge) begin
      cnt_q <= CW'(1);
      len_q <= len_pick; // R7
    end else if (state_q == sar_sequencer_pkg::PH_CONVERT && osc_en && !conv_done) begin
      cnt_q <= cnt_q + CW'(1); // R2
    end
  end

  // successive approximation on the offset-binary form of the held difference
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      approx_q <= '0;
      trial_q <= '0;
    end else if (state_q == sar_sequencer_pkg::PH_ACQUIRE && start_edge) begin
      approx_q <= '0;
      trial_q <= {1'b1, {(WIDTH-1){1'b0}}};
    end else if (core.step) begin
      if ((approx_q | trial_q) <= (core.held ^ {1'b1, {(WIDTH-1){1'b0}}}))
        approx_q <= approx_q | trial_q; // R9
      trial_q <= trial_q >> 1;
    end
  end

  // registered outputs
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conversion_status_o <= 1'b0;
      result_o <= '0;
      convert_phase_o <= 1'b0;
      sample_switch_o <= 1'b0;
      xfer_use_osc_o <= 1'b1;
      xfer_use_host_o <= 1'b0;
    end else begin
      conversion_status_o <= (state_d == sar_sequencer_pkg::PH_ACQUIRE); // R12 R5
      if (conv_done)
        result_o <= approx_q ^ {1'b1, {(WIDTH-1){1'b0}}}; // R6 R5
      convert_phase_o <= (state_d == sar_sequencer_pkg::PH_CONVERT);
      sample_switch_o <= (state_d == sar_sequencer_pkg::PH_ACQUIRE); // R3 R4
      xfer_use_osc_o <= (xfer_source_i != `XFER_SRC_HOST); // R8
      xfer_use_host_o <= (xfer_source_i != `XFER_SRC_OSC); // R8
    end
  end

  // length of each conversion as seen on the phase output, for the bound check
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_run_q <= '0;
    end else if (convert_phase_o) begin
      conv_run_q <= conv_run_q + CW'(1); // R7
    end else begin
      conv_run_q <= '0;
    end
  end

  // checks
  chk_start_enters_conv: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R10
    (state_q == sar_sequencer_pkg::PH_ACQUIRE && start_edge) |=> convert_phase_o)
    else $error("start edge did not begin conversion");
  chk_status_low_conv: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R12
    convert_phase_o |-> !conversion_status_o)
    else $error("status high during conversion");
  chk_switch_open_conv: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
    convert_phase_o |-> !sample_switch_o)
    else $error("inputs connected during conversion");
  chk_conv_len_bound: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R7
    $fell(convert_phase_o) |-> (conv_run_q >= MIN_C) && (conv_run_q <= MAX_C))
    else $error("conversion length out of bounds");
  chk_end_to_acquire: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R4
    $fell(convert_phase_o) |-> sample_switch_o && conversion_status_o)
    else $error("no return to acquisition");
  chk_ignore_start: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R11
    (state_q == sar_sequencer_pkg::PH_CONVERT && !conv_done) |=> state_q == sar_sequencer_pkg::PH_CONVERT)
    else $error("conversion aborted early");
  chk_sign_bit: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R6
    conv_done |=> result_o[WIDTH-1] == $past(core.held[WIDTH-1]))
    else $error("result sign wrong");
  chk_reset_to_acq: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R13
    state_q == sar_sequencer_pkg::PH_RESET |=> state_q == sar_sequencer_pkg::PH_ACQUIRE)
    else $error("reset did not enter acquisition");
  chk_xfer_select: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R8
    xfer_source_i == `XFER_SRC_MIXED |=> xfer_use_osc_o && xfer_use_host_o)
    else $error("mixed transfer clock not selected");
  // late start edges, length window, result hold and completion
  chk_no_stale_start: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R11
    $fell(convert_phase_o) |-> !convert_phase_o [*3])
    else $error("start change during conversion began another");
  chk_track_open_conv: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
    (state_q == sar_sequencer_pkg::PH_CONVERT) |-> !core.track)
    else $error("array tracking during conversion");
  chk_result_held: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R5
    !conv_done |=> $stable(result_o))
    else $error("result changed outside conversion end");
  chk_status_at_end: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R12
    conv_done |=> conversion_status_o)
    else $error("status not high after conversion end");
  chk_len_window: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R7
    (state_q == sar_sequencer_pkg::PH_ACQUIRE && start_edge) |=> (len_q >= MIN_C) && (len_q <= MAX_C))
    else $error("picked conversion length out of window");
  chk_sar_complete: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R9
    conv_done |-> (trial_q == '0))
    else $error("conversion ended before all bits resolved");
endmodule : sar_conversion_sequencer

// ==== sar_host_model.sv ====
module sar_host_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // bench commands
  input wire logic req_i,
  input wire logic hold_i,
  input wire logic toggle_i,
  // status in, start out
  input wire logic conversion_status_i,
  output logic conversion_start_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // toggling stops after this many conversion cycles, well inside the shortest conversion
  localparam int TOGGLE_CYC = 8;
  logic [3:0] low_cnt_q;
  // cycles since status fell, saturating
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_cnt_q <= 4'h0;
    end else if (conversion_status_i) begin
      low_cnt_q <= 4'h0;
    end else if (low_cnt_q != 4'hF) begin
      low_cnt_q <= low_cnt_q + 4'h1;
    end
  end
  // start stays low in reset, rises on request while acquiring, and may toggle early in a conversion when toggle_i is set
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conversion_start_o <= 1'b0;
    end else if (conversion_status_i) begin
      conversion_start_o <= req_i | (hold_i & conversion_start_o);
    end else begin
      conversion_start_o <= (toggle_i && low_cnt_q < 4'(TOGGLE_CYC)) ? ~conversion_start_o :
        (hold_i & conversion_start_o);
    end
  end
endmodule : sar_host_model

// ==== sar_conversion_sequencer_tb_top.sv ====
`include "sar_sequencer_params.svh"
module sar_conversion_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic req = 1'b0;
  logic hold = 1'b0;
  logic toggle = 1'b0;
  logic [1:0] xfer = 2'h0;
  logic signed [17:0] pos = 18'h0;
  logic signed [17:0] neg = 18'h0;
  logic start, status, phase, switch, use_osc, use_host;
  logic [17:0] result;
  int n_errors = 0;
  int num_checks = 0;
  // 50 MHz clock
  always #10 clk_i = ~clk_i;
  sar_conversion_sequencer DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .conversion_start_i(start),
    .xfer_source_i(xfer), .analog_in_pos_i(pos), .analog_in_neg_i(neg),
    .conversion_status_o(status), .result_o(result), .convert_phase_o(phase),
    .sample_switch_o(switch), .xfer_use_osc_o(use_osc), .xfer_use_host_o(use_host));
  sar_host_model host (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .hold_i(hold),
    .toggle_i(toggle), .conversion_status_i(status), .conversion_start_o(start));
  // verdict and end of run
  task end_sim;
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // bounded wait for a status level
  task wait_status(input logic lvl);
    for (int i = 0; i < 40 && status !== lvl; i++) @(negedge clk_i);
    if (status !== lvl) begin
      n_errors++;
      end_sim();
    end
  endtask : wait_status
  // one conversion, checked for result, length and phase outputs
  task convert(input int p, input int n, input logic hd, input logic tg);
    int len;
    int e;
    @(posedge clk_i);
    pos <= p[17:0];
    neg <= n[17:0];
    hold <= hd;
    toggle <= tg;
    req <= 1'b1;
    @(posedge clk_i);
    req <= 1'b0;
    wait_status(1'b0);
    `CHK("switch_open", 1'b0, switch)
    `CHK("phase_high", 1'b1, phase)
    len = 0;
    while (status === 1'b0 && len < 40) begin
      @(negedge clk_i);
      len++;
    end
    if (status !== 1'b1) begin
      n_errors++;
      end_sim();
    end
    e = p - n;
    if (e > 131071) e = 131071;
    if (e < -131072) e = -131072;
    `CHK("result", e[17:0], result)
    `CHK("sign_bit", e < 0, result[17])
    `CHK("conv_len", 1'b1, len >= `CONV_MIN_CYC && len <= `CONV_MAX_CYC)
    `CHK("switch_back", 1'b1, switch)
    `CHK("phase_low", 1'b0, phase)
    repeat (8) @(negedge clk_i);
    `CHK("no_restart", 1'b1, status)
    @(posedge clk_i);
    hold <= 1'b0;
    toggle <= 1'b0;
  endtask : convert
  // reset during a conversion returns to acquisition
  task reset_mid;
    @(posedge clk_i);
    req <= 1'b1;
    @(posedge clk_i);
    req <= 1'b0;
    wait_status(1'b0);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    @(negedge clk_i);
    `CHK("rst_status", 1'b0, status)
    `CHK("rst_phase", 1'b0, phase)
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    `CHK("rst_exit", 1'b1, status & switch)
  endtask : reset_mid
  // transfer clock source decode for every code
  task xfer_modes;
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_i);
      xfer <= s[1:0];
      repeat (2) @(negedge clk_i);
      `CHK("use_osc", s != 1, use_osc)
      `CHK("use_host", s != 0, use_host)
    end
  endtask : xfer_modes
  // main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    `CHK("in_reset", 1'b0, status | switch)
    rst_b_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    `CHK("powerup_acq", 1'b1, status & switch)
    xfer_modes();
    convert(100, 40, 1'b0, 1'b0);
    convert(-50, 25, 1'b1, 1'b0);
    convert(131071, -131072, 1'b0, 1'b1);
    convert(-131072, 131071, 1'b0, 1'b0);
    convert(7, 7, 1'b0, 1'b0);
    reset_mid();
    convert(-1, 0, 1'b0, 1'b0);
    end_sim();
  end
endmodule : sar_conversion_sequencer_tb_top
